// ---- bench/pcr_far_model.sv ----
`timescale 1ns/1ns
module pcr_far_model (
    input wire logic mclk,
    input wire logic [2:0] src_on,
    input wire logic [3:0] div_tick,
    input wire logic pin_low_req,
    output logic slow_osc,
    output logic main_osc,
    output logic external_clock_input,
    output logic reset_pin_n,
    output logic [3:0][15:0] gap,
    output logic overlap
);
    logic [3:0][15:0] cnt;

    // Pad pull-up unless a party pulls low
    assign reset_pin_n = pin_low_req ? 1'b0 : 1'b1;

    initial begin
        slow_osc = 1'b0;
        main_osc = 1'b0;
        external_clock_input = 1'b0;
        overlap = 1'b0;
        cnt = '0;
        gap = '0;
    end

    always #12500 slow_osc = ~slow_osc;
    always #21 main_osc = ~main_osc;
    always #50 external_clock_input = ~external_clock_input;

    // Consumers watch for overlapping sources and tick spacing
    always @(posedge mclk) begin
        if ($countones(src_on) > 1) begin
            overlap <= 1'b1;
        end
        for (int i = 0; i < 4; i++) begin
            cnt[i] <= div_tick[i] ? 16'h1 : cnt[i] + 16'h1;
            if (div_tick[i]) begin
                gap[i] <= cnt[i];
            end
        end
    end
endmodule

// ---- bench/power_clock_reset_control_tb.sv ----
`timescale 1ns/1ns
module power_clock_reset_control_tb;
    logic MCLK, RST, SUPPLY_OK, BROWN_OUT, WAKE_EVENT, WR, RD, pin_low_req;
    logic SLOW, MAIN, EXT, PIN_N, SYS_RESET, CPU_CLK_EN, MAIN_OSC_EN, M32, IRQ, overlap;
    logic [pcr_pkg::ADDR_W-1:0] ADDR;
    logic [31:0] WDATA, RDATA, rv;
    logic [2:0] SRC_ON;
    logic [3:0] DIV_TICK;
    logic [3:0][15:0] gap;
    int num_errors, checks;

    pcr_top dut (
        .MCLK(MCLK), .RST(RST), .SUPPLY_OK(SUPPLY_OK), .BROWN_OUT(BROWN_OUT),
        .EXTERNAL_RESET_PIN_N(PIN_N), .SLOW_INTERNAL_OSCILLATOR(SLOW),
        .EXTERNAL_CLOCK_INPUT(EXT), .MAIN_INTERNAL_OSCILLATOR(MAIN),
        .WAKE_EVENT(WAKE_EVENT), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .SYS_RESET(SYS_RESET), .CPU_CLK_EN(CPU_CLK_EN),
        .MAIN_OSC_EN(MAIN_OSC_EN), .MAIN_OSC_32MHZ(M32), .SRC_ON(SRC_ON),
        .DIV_TICK(DIV_TICK), .IRQ(IRQ)
    );

    pcr_far_model far (
        .mclk(MCLK), .src_on(SRC_ON), .div_tick(DIV_TICK), .pin_low_req(pin_low_req),
        .slow_osc(SLOW), .main_osc(MAIN), .external_clock_input(EXT), .reset_pin_n(PIN_N),
        .gap(gap), .overlap(overlap)
    );

    // ----------------------------------------
    // Clock, verdict and hang guard
    // ----------------------------------------
    initial begin
        MCLK = 1'b0;
        forever #20 MCLK = ~MCLK;
    end

    task automatic conclude;
        if (num_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #(40 * 60000);
        num_errors++;
        conclude();
    end

    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk1(input string name, input logic exp, input logic got);
        check(name, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge MCLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string name);
        @(posedge MCLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge MCLK);
        RD <= 1'b0;
        #1;
        rv = RDATA;
        check(name, e, rv & m);
    endtask

    task automatic wait_sys(input logic lvl, input int lim);
        int n;
        n = 0;
        while (SYS_RESET !== lvl && n < lim) begin
            @(posedge MCLK);
            n++;
        end
        #1;
        chk1("sys reset level", lvl, SYS_RESET);
    endtask

    task automatic reset_seen(input int b);
        wait_sys(1'b1, 5000);
        wait_sys(1'b0, 100);
        rd(pcr_pkg::REG_CAUSE, 32'h1 << b, 32'h1 << b, "cause flag");
        wr(pcr_pkg::REG_CAUSE, 32'h1f);
        rd(pcr_pkg::REG_CAUSE, 32'h1f, 32'h0, "cause cleared");
        rd(pcr_pkg::REG_CTRL, 32'h7f, 32'h0, "ctrl after reset");
    endtask

    task automatic wake(input int lo, input int hi);
        int n;
        n = 0;
        @(posedge MCLK);
        WAKE_EVENT <= 1'b1;
        while (CPU_CLK_EN !== 1'b1 && n < 1000) begin
            @(posedge MCLK);
            n++;
        end
        WAKE_EVENT <= 1'b0;
        chk1("wake latency", 1'b1, n >= lo && n <= hi);
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        RST = 1'b1;
        SUPPLY_OK = 1'b0;
        BROWN_OUT = 1'b0;
        WAKE_EVENT = 1'b0;
        WR = 1'b0;
        RD = 1'b0;
        ADDR = '0;
        WDATA = '0;
        pin_low_req = 1'b0;
        num_errors = 0;
        checks = 0;
        repeat (6) @(posedge MCLK);
        RST <= 1'b0;
        step(40);
        chk1("held for supply", 1'b1, SYS_RESET);
        @(posedge MCLK);
        SUPPLY_OK <= 1'b1;
        wait_sys(1'b0, 100);
        rd(pcr_pkg::REG_CAUSE, 32'h1, 32'h1, "power-on cause");
        wr(pcr_pkg::REG_CAUSE, 32'h1f);
        chk1("cpu clock on", 1'b1, CPU_CLK_EN);
        chk1("main osc on", 1'b1, MAIN_OSC_EN);
        chk1("24 MHz default", 1'b0, M32);
        check("source after reset", 32'h1, {29'h0, SRC_ON});
        wr(4'hb, 32'hffff);
        rd(pcr_pkg::REG_WDT_LIMIT, 32'hffffffff, pcr_pkg::WDT_LIMIT_RST, "wdt limit");
        wr(pcr_pkg::REG_CTRL, 32'h10);
        step(2);
        chk1("32 MHz select", 1'b1, M32);
        for (int s = 1; s < 4; s++) begin
            wr(pcr_pkg::REG_CTRL, 32'(s % 3) << 2);
            for (int n = 0; n < 3000 && SRC_ON !== (3'b001 << (s % 3)); n++) step(1);
            check("source select", 32'h1 << (s % 3), {29'h0, SRC_ON});
        end
        chk1("no source overlap", 1'b0, overlap);
        rd(pcr_pkg::REG_IRQ_STAT, 32'h4, 32'h4, "switch done flag");
        for (int i = 0; i < 4; i++) wr(pcr_pkg::REG_DIV0 + 4'(i), 32'(i + 2));
        step(30);
        for (int i = 0; i < 4; i++) check("div period", 32'(i + 3), {16'h0, gap[i]});
        wr(pcr_pkg::REG_IRQ_STAT, 32'h7);
        wr(pcr_pkg::REG_CAL_WIN, 32'h2);
        step(2000);
        rd(pcr_pkg::REG_IRQ_STAT, 32'h2, 32'h2, "cal done flag");
        rd(pcr_pkg::REG_CAL_COUNT, 32'h0, 32'h0, "cal read");
        chk1("cal count range", 1'b1, rv >= 625 && rv <= 1255);
        wr(pcr_pkg::REG_IRQ_STAT, 32'h7);
        wr(pcr_pkg::REG_CTRL, 32'h1);
        step(3);
        chk1("sleep cpu clock", 1'b0, CPU_CLK_EN);
        chk1("sleep main osc", 1'b1, MAIN_OSC_EN);
        wake(1, 4);
        wr(pcr_pkg::REG_IRQ_MASK, 32'h1);
        step(2);
        chk1("irq unmasked", 1'b1, IRQ);
        wr(pcr_pkg::REG_IRQ_MASK, 32'h0);
        step(2);
        chk1("irq masked", 1'b0, IRQ);
        wr(pcr_pkg::REG_IRQ_MASK, 32'h1);
        wr(pcr_pkg::REG_IRQ_STAT, 32'h7);
        step(2);
        chk1("irq cleared", 1'b0, IRQ);
        wr(pcr_pkg::REG_CTRL, 32'h2);
        step(3);
        chk1("deep main osc off", 1'b0, MAIN_OSC_EN);
        chk1("deep cpu clock", 1'b0, CPU_CLK_EN);
        wake(pcr_pkg::DEEP_WAKE_CYC, pcr_pkg::DEEP_WAKE_CYC + 10);
        chk1("main osc back", 1'b1, MAIN_OSC_EN);
        wr(pcr_pkg::REG_WDT_LIMIT, 32'h2);
        wr(pcr_pkg::REG_CTRL, 32'h20);
        reset_seen(pcr_pkg::CAUSE_WDT);
        wr(pcr_pkg::REG_CTRL, 32'h40);
        reset_seen(pcr_pkg::CAUSE_SW);
        @(posedge MCLK);
        pin_low_req <= 1'b1;
        step(3);
        @(posedge MCLK);
        pin_low_req <= 1'b0;
        reset_seen(pcr_pkg::CAUSE_EXTERNAL_RESET_PIN);
        @(posedge MCLK);
        BROWN_OUT <= 1'b1;
        step(3);
        @(posedge MCLK);
        BROWN_OUT <= 1'b0;
        reset_seen(pcr_pkg::CAUSE_BOD);
        conclude();
    end
endmodule

// ---- src/pcr_pkg.sv ----
package pcr_pkg;

    // ------------------------------------------------------------
    // Bus and registers
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CAUSE = 4'h1;
    localparam logic [3:0] REG_IRQ_STAT = 4'h2;
    localparam logic [3:0] REG_IRQ_MASK = 4'h3;
    localparam logic [3:0] REG_WDT_LIMIT = 4'h4;
    localparam logic [3:0] REG_WDT_KICK = 4'h5;
    localparam logic [3:0] REG_CAL_WIN = 4'h6;
    localparam logic [3:0] REG_CAL_COUNT = 4'h7;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_DIV0 = 4'hc;

    // CTRL fields
    localparam int CTRL_SLEEP = 0;
    localparam int CTRL_DEEP = 1;
    localparam int CTRL_CLKSEL_LO = 2;
    localparam int CTRL_FREQ32 = 4;
    localparam int CTRL_WDT_EN = 5;
    localparam int CTRL_SWRST = 6;
    localparam logic [31:0] SWRST_KEY_MASK = 32'h0000_0040;

    // Reset cause flags
    localparam int CAUSE_POR = 0;
    localparam int CAUSE_BOD = 1;
    localparam int CAUSE_EXTERNAL_RESET_PIN = 2;
    localparam int CAUSE_WDT = 3;
    localparam int CAUSE_SW = 4;
    localparam int CAUSE_W = 5;

    // Interrupt events
    localparam int IRQ_WAKE = 0;
    localparam int IRQ_CAL_DONE = 1;
    localparam int IRQ_CLK_DONE = 2;
    localparam int IRQ_W = 3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 25;
    localparam int DEEP_WAKE_US = 35;
    localparam int DEEP_WAKE_CYC = DEEP_WAKE_US * CLK_MHZ;
    localparam int RST_STRETCH_CYC = 16;
    localparam int N_DIV = 4;
    localparam int DIV_W = 16;
    localparam logic [31:0] WDT_LIMIT_RST = 32'h0000_0400;
    localparam logic [31:0] CAL_WIN_RST = 32'h0000_0010;

    typedef enum logic [1:0] {
        PCR_SRC_MAIN = 2'h0,
        PCR_SRC_SLOW = 2'h1,
        PCR_SRC_EXT = 2'h2
    } pcr_src_t;

    typedef enum logic [4:0] {
        PCR_ACTIVE = 5'h01,
        PCR_SLEEP = 5'h02,
        PCR_DEEP = 5'h04,
        PCR_WAKEUP = 5'h08,
        PCR_HOLD = 5'h10
    } pcr_mode_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } pcr_bus_t;

    typedef struct packed {
        logic cpu_clk_en;
        logic main_osc_en;
        logic main_osc_32;
        logic [2:0] src_on;
    } pcr_clk_t;

endpackage

// ---- src/pcr_top.sv ----
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
module pcr_top (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic SUPPLY_OK,
    input wire logic BROWN_OUT,
    input wire logic EXTERNAL_RESET_PIN_N,
    input wire logic SLOW_INTERNAL_OSCILLATOR,
    input wire logic EXTERNAL_CLOCK_INPUT,
    input wire logic MAIN_INTERNAL_OSCILLATOR,
    input wire logic WAKE_EVENT,
    input wire logic [pcr_pkg::ADDR_W-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output logic SYS_RESET,
    output logic CPU_CLK_EN,
    output logic MAIN_OSC_EN,
    output logic MAIN_OSC_32MHZ,
    output logic [2:0] SRC_ON,
    output logic [pcr_pkg::N_DIV-1:0] DIV_TICK,
    output logic IRQ
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        pcr_pkg::pcr_mode_t mode;
        logic [15:0] wake_cnt;
        logic [4:0] rst_cnt;
        logic [31:0] ctrl;
        logic [pcr_pkg::IRQ_W-1:0] irq_stat;
        logic [pcr_pkg::IRQ_W-1:0] irq_mask;
        logic [31:0] wdt_limit;
        logic [31:0] wdt_cnt;
        logic wdt_fire;
        logic [31:0] cal_win;
        logic [31:0] cal_slow;
        logic [31:0] cal_fast;
        logic [31:0] cal_count;
        logic cal_run;
        logic [pcr_pkg::N_DIV-1:0][pcr_pkg::DIV_W-1:0] div_val;
        logic [pcr_pkg::N_DIV-1:0][pcr_pkg::DIV_W-1:0] div_cnt;
        logic [pcr_pkg::N_DIV-1:0] div_tick;
        pcr_pkg::pcr_src_t src_cur;
        logic [2:0] src_on;
        logic [31:0] rdata;
        logic [1:0] slow_sy;
        logic slow_prev;
        logic [1:0] wake_sy;
        logic [1:0] sup_sy;
        logic [1:0] bod_sy;
        logic [1:0] external_reset_pin_sy;
        logic sw_req;
    } pcr_state_t;

    pcr_state_t q;
    pcr_state_t d;
    logic [pcr_pkg::CAUSE_W-1:0] cause;
    logic [pcr_pkg::CAUSE_W-1:0] next_cause;
    logic seen_power;
    logic sys_rst;
    logic slow_tick;
    logic [pcr_pkg::CAUSE_W-1:0] cause_evt;
    logic [pcr_pkg::DIV_W-1:0] next_div_cnt [pcr_pkg::N_DIV];
    logic next_div_tick [pcr_pkg::N_DIV];
    localparam logic [15:0] WAKE_CYC = 16'(pcr_pkg::DEEP_WAKE_CYC);
    localparam logic [4:0] STRETCH = 5'(pcr_pkg::RST_STRETCH_CYC);

    assign slow_tick = q.slow_sy[1] & ~q.slow_prev;
    // Soft reset: watchdog, software, brown-out, pin, supply not good
    assign sys_rst = q.rst_cnt != 5'h00;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.slow_sy = {q.slow_sy[0], SLOW_INTERNAL_OSCILLATOR};
        d.slow_prev = q.slow_sy[1];
        d.wake_sy = {q.wake_sy[0], WAKE_EVENT};
        d.sup_sy = {q.sup_sy[0], SUPPLY_OK};
        d.bod_sy = {q.bod_sy[0], BROWN_OUT};
        d.external_reset_pin_sy = {q.external_reset_pin_sy[0], EXTERNAL_RESET_PIN_N};
        d.wdt_fire = 1'b0;
        d.sw_req = 1'b0;
        for (int i = 0; i < pcr_pkg::N_DIV; i++) begin
            d.div_cnt[i] = next_div_cnt[i];
            d.div_tick[i] = next_div_tick[i];
        end
        d.rdata = '0;
        cause_evt = '0;
        cause_evt[pcr_pkg::CAUSE_BOD] = q.bod_sy[1];
        cause_evt[pcr_pkg::CAUSE_EXTERNAL_RESET_PIN] = ~q.external_reset_pin_sy[1];
        cause_evt[pcr_pkg::CAUSE_WDT] = q.wdt_fire;
        cause_evt[pcr_pkg::CAUSE_SW] = q.sw_req;

        // Reset stretcher
        if (!q.sup_sy[1] || cause_evt != '0) begin
            d.rst_cnt = STRETCH;
        end else if (q.rst_cnt != 5'h00) begin
            d.rst_cnt = q.rst_cnt - 5'h01;
        end

        // Power mode sequencer
        case (q.mode)
            pcr_pkg::PCR_ACTIVE: begin
                if (q.ctrl[pcr_pkg::CTRL_DEEP]) begin
                    d.mode = pcr_pkg::PCR_DEEP;
                end else if (q.ctrl[pcr_pkg::CTRL_SLEEP]) begin
                    d.mode = pcr_pkg::PCR_SLEEP;
                end
            end
            pcr_pkg::PCR_SLEEP: begin
                if (q.wake_sy[1]) begin
                    d.mode = pcr_pkg::PCR_ACTIVE;
                    d.ctrl[pcr_pkg::CTRL_SLEEP] = 1'b0;
                    d.irq_stat[pcr_pkg::IRQ_WAKE] = 1'b1;
                end
            end
            pcr_pkg::PCR_DEEP: begin
                if (q.wake_sy[1]) begin
                    d.mode = pcr_pkg::PCR_WAKEUP;
                    d.wake_cnt = WAKE_CYC - 16'h0001;
                end
            end
            pcr_pkg::PCR_WAKEUP: begin
                if (q.wake_cnt == 16'h0000) begin
                    d.mode = pcr_pkg::PCR_ACTIVE;
                    d.ctrl[pcr_pkg::CTRL_DEEP] = 1'b0;
                    d.ctrl[pcr_pkg::CTRL_SLEEP] = 1'b0;
                    d.irq_stat[pcr_pkg::IRQ_WAKE] = 1'b1;
                end else begin
                    d.wake_cnt = q.wake_cnt - 16'h0001;
                end
            end
            pcr_pkg::PCR_HOLD: begin
                if (!sys_rst) begin
                    d.mode = pcr_pkg::PCR_ACTIVE;
                end
            end
            default: d.mode = pcr_pkg::PCR_HOLD;
        endcase

        // Glitch-free source switch: old off before new on
        if (q.src_cur != pcr_pkg::pcr_src_t'(q.ctrl[pcr_pkg::CTRL_CLKSEL_LO +: 2])) begin
            if (q.src_on != 3'h0) begin
                d.src_on = 3'h0;
            end else if (q.ctrl[pcr_pkg::CTRL_CLKSEL_LO +: 2] <= 2'(pcr_pkg::PCR_SRC_EXT)) begin
                d.src_cur = pcr_pkg::pcr_src_t'(q.ctrl[pcr_pkg::CTRL_CLKSEL_LO +: 2]);
                d.src_on = 3'h1 << q.ctrl[pcr_pkg::CTRL_CLKSEL_LO +: 2];
                d.irq_stat[pcr_pkg::IRQ_CLK_DONE] = 1'b1;
            end
        end

        // Watchdog on slow ticks
        if (!q.ctrl[pcr_pkg::CTRL_WDT_EN]) begin
            d.wdt_cnt = '0;
        end else if (slow_tick) begin
            if (q.wdt_cnt >= q.wdt_limit) begin
                d.wdt_fire = 1'b1;
                d.wdt_cnt = '0;
            end else begin
                d.wdt_cnt = q.wdt_cnt + 32'h1;
            end
        end

        // Calibration: core cycles over a window of slow ticks
        if (q.cal_run) begin
            d.cal_fast = q.cal_fast + 32'h1;
            if (slow_tick) begin
                d.cal_slow = q.cal_slow + 32'h1;
                if (q.cal_slow + 32'h1 >= q.cal_win) begin
                    d.cal_run = 1'b0;
                    d.cal_count = q.cal_fast + 32'h1;
                    d.irq_stat[pcr_pkg::IRQ_CAL_DONE] = 1'b1;
                end
            end
        end

        // Register writes
        if (WR) begin
            case (ADDR)
                pcr_pkg::REG_CTRL: begin
                    d.ctrl = WDATA;
                    d.ctrl[pcr_pkg::CTRL_SWRST] = 1'b0;
                    d.sw_req = |(WDATA & pcr_pkg::SWRST_KEY_MASK);
                end
                pcr_pkg::REG_IRQ_STAT: d.irq_stat = q.irq_stat & ~WDATA[pcr_pkg::IRQ_W-1:0];
                pcr_pkg::REG_IRQ_MASK: d.irq_mask = WDATA[pcr_pkg::IRQ_W-1:0];
                pcr_pkg::REG_WDT_LIMIT: d.wdt_limit = WDATA;
                pcr_pkg::REG_WDT_KICK: d.wdt_cnt = '0;
                pcr_pkg::REG_CAL_WIN: begin
                    d.cal_win = WDATA;
                    d.cal_run = 1'b1;
                    d.cal_slow = '0;
                    d.cal_fast = '0;
                end
                default: d.ctrl = q.ctrl;
            endcase
            if (ADDR >= pcr_pkg::REG_DIV0) begin
                d.div_val[2'(ADDR - pcr_pkg::REG_DIV0)] = WDATA[pcr_pkg::DIV_W-1:0];
            end
        end
        // Wake events set after clears so a same-cycle set wins
        if (q.mode == pcr_pkg::PCR_SLEEP && q.wake_sy[1]) begin
            d.irq_stat[pcr_pkg::IRQ_WAKE] = 1'b1;
        end
        if (q.mode == pcr_pkg::PCR_WAKEUP && q.wake_cnt == 16'h0000) begin
            d.irq_stat[pcr_pkg::IRQ_WAKE] = 1'b1;
        end

        // Register reads
        if (RD) begin
            case (ADDR)
                pcr_pkg::REG_CTRL: d.rdata = q.ctrl;
                pcr_pkg::REG_CAUSE: d.rdata = 32'(cause);
                pcr_pkg::REG_IRQ_STAT: d.rdata = 32'(q.irq_stat);
                pcr_pkg::REG_IRQ_MASK: d.rdata = 32'(q.irq_mask);
                pcr_pkg::REG_WDT_LIMIT: d.rdata = q.wdt_limit;
                pcr_pkg::REG_WDT_KICK: d.rdata = q.wdt_cnt;
                pcr_pkg::REG_CAL_WIN: d.rdata = q.cal_win;
                pcr_pkg::REG_CAL_COUNT: d.rdata = q.cal_count;
                pcr_pkg::REG_STATUS: d.rdata = {24'h0, q.cal_run, q.src_on, 1'b0, q.src_cur[0],
                                                q.mode == pcr_pkg::PCR_DEEP,
                                                q.mode == pcr_pkg::PCR_SLEEP};
                default: d.rdata = '0;
            endcase
            if (ADDR >= pcr_pkg::REG_DIV0) begin
                d.rdata = 32'(q.div_val[2'(ADDR - pcr_pkg::REG_DIV0)]);
            end
        end
    end

    // ------------------------------------------------------------
    // Dividers
    // ------------------------------------------------------------
    for (genvar i = 0; i < pcr_pkg::N_DIV; i++) begin : g_div
        assign next_div_tick[i] = q.div_cnt[i] == 16'h0000;
        assign next_div_cnt[i] = next_div_tick[i] ? q.div_val[i]
                                                  : q.div_cnt[i] - 16'h0001;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            q <= '0;
            q.mode <= pcr_pkg::PCR_HOLD;
            q.rst_cnt <= 5'(pcr_pkg::RST_STRETCH_CYC);
            q.wdt_limit <= pcr_pkg::WDT_LIMIT_RST;
            q.cal_win <= pcr_pkg::CAL_WIN_RST;
            q.src_cur <= pcr_pkg::PCR_SRC_MAIN;
            q.src_on <= 3'h1;
            q.external_reset_pin_sy <= 2'h3;
        end else if (sys_rst) begin
            // Stretcher and synchronisers keep running through system reset
            q <= '0;
            q.mode <= pcr_pkg::PCR_HOLD;
            q.rst_cnt <= d.rst_cnt;
            q.wdt_limit <= pcr_pkg::WDT_LIMIT_RST;
            q.cal_win <= pcr_pkg::CAL_WIN_RST;
            q.src_cur <= pcr_pkg::PCR_SRC_MAIN;
            q.src_on <= 3'h1;
            q.slow_sy <= d.slow_sy;
            q.slow_prev <= d.slow_prev;
            q.wake_sy <= d.wake_sy;
            q.sup_sy <= d.sup_sy;
            q.bod_sy <= d.bod_sy;
            q.external_reset_pin_sy <= d.external_reset_pin_sy;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Cause record, outside system reset
    // ------------------------------------------------------------
    always_comb begin
        next_cause = cause | cause_evt;
        if (!seen_power) begin
            next_cause[pcr_pkg::CAUSE_POR] = 1'b1;
        end
        if (WR && ADDR == pcr_pkg::REG_CAUSE && !sys_rst) begin
            next_cause = (cause & ~WDATA[pcr_pkg::CAUSE_W-1:0]) | cause_evt;
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            cause <= '0;
            seen_power <= 1'b0;
        end else begin
            cause <= next_cause;
            seen_power <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign RDATA = q.rdata;
    assign SYS_RESET = sys_rst;
    assign CPU_CLK_EN = q.mode == pcr_pkg::PCR_ACTIVE;
    assign MAIN_OSC_EN = q.mode != pcr_pkg::PCR_DEEP;
    assign MAIN_OSC_32MHZ = q.ctrl[pcr_pkg::CTRL_FREQ32];
    assign SRC_ON = q.src_on;
    assign DIV_TICK = q.div_tick;
    assign IRQ = |(q.irq_stat & q.irq_mask);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_DEEP_WAKE: assert property (@(posedge MCLK) disable iff (RST || sys_rst)
        q.mode == pcr_pkg::PCR_DEEP && q.wake_sy[1]
        |=> q.mode == pcr_pkg::PCR_WAKEUP [*8])
        else $error("Deep wake too short");
    AST_SLEEP_GATE: assert property (@(posedge MCLK) disable iff (RST)
        q.mode == pcr_pkg::PCR_SLEEP |-> !CPU_CLK_EN && MAIN_OSC_EN)
        else $error("Sleep gating wrong");
    AST_SLEEP_WAKE: assert property (@(posedge MCLK) disable iff (RST || sys_rst)
        q.mode == pcr_pkg::PCR_SLEEP && q.wake_sy[1] |=> CPU_CLK_EN)
        else $error("Sleep wake late");
    AST_BREAK: assert property (@(posedge MCLK) disable iff (RST || sys_rst)
        $changed(q.src_cur) |-> $past(q.src_on) == 3'h0)
        else $error("Source switched without break");
    AST_ONEHOT: assert property (@(posedge MCLK) disable iff (RST)
        $onehot0(SRC_ON))
        else $error("Two sources on");
    AST_WDT_RST: assert property (@(posedge MCLK) disable iff (RST)
        q.wdt_fire |=> SYS_RESET && cause[pcr_pkg::CAUSE_WDT])
        else $error("Watchdog reset missing");
    AST_BOD: assert property (@(posedge MCLK) disable iff (RST)
        q.bod_sy[1] |=> SYS_RESET [*8])
        else $error("Brown-out reset missing");
    AST_STICKY: assert property (@(posedge MCLK) disable iff (RST)
        $fell(cause[pcr_pkg::CAUSE_WDT]) |-> $past(WR) && $past(ADDR) == pcr_pkg::REG_CAUSE)
        else $error("Cause lost");
    AST_DIV: assert property (@(posedge MCLK) disable iff (RST || sys_rst)
        DIV_TICK[0] && q.div_val[0] == 16'h0002 && $stable(q.div_val[0])
        |=> !DIV_TICK[0] ##1 !DIV_TICK[0])
        else $error("Divider period wrong");
    CV_SLEEP: cover property (@(posedge MCLK) q.mode == pcr_pkg::PCR_SLEEP ##1 CPU_CLK_EN);
    CV_DEEP: cover property (@(posedge MCLK) q.mode == pcr_pkg::PCR_WAKEUP ##1 CPU_CLK_EN);
    CV_WDT: cover property (@(posedge MCLK) q.wdt_fire);
    CV_SWITCH: cover property (@(posedge MCLK) $changed(q.src_cur));

endmodule
